// ---- src/ssl_support.sv ----
// ssl_support: management-mode flush, cache, gate and config window logic
//
// How it works
// RULE1: enabled flush pulses low four cycles on entry
// RULE2: no flush pulse for strobe-type processors
// RULE3: never flush on exit nor secondary cache
// RULE4: 94h bit 3 makes mode space L1-uncached
// RULE5: 18h bit 3 sets shadow region L2 cacheability
// RULE6: 18h=10 plus 94h.3 uncaches both caches
// RULE7: 94h bit 2 ORs active mode into gate
// RULE8: forced gate sends set/clear link codes
// RULE9: gate already high means no codes sent
// RULE10: no gate forcing for strobe-type processors
// RULE11: second window at ports 26 and 27
// RULE12: second window owns index and accessed flag
// RULE13: both windows reach same configuration registers
// RULE14: software picks window by its own mode
// RULE15: port 70 writes readable at index 96h
// RULE16: mode code saves, uses, restores port 70
// RULE17: no processor-type register, separate feature controls (code: 94h bit 5 selects strobe type)
// RULE18: static processor holds active level over cycles
// RULE19: strobe processor marks each mode cycle
// RULE20: flush line idles high outside pulse
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ps
`include "ssl_regs.svh"
module ssl_support (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [9:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        mgmt_mode_active_n,
   input  wire logic        mgmt_mode_addr_strobe_n,
   input  wire logic        kbd_addr_bit20_gate,
   input  wire logic        emu_addr_bit20_gate,
   output logic             cache_flush_n,
   output logic             addr_bit20_gate,
   output logic             gate_set_link_code,
   output logic             gate_clear_link_code,
   output logic             l1_smm_noncache,
   output logic             l2_shadow_noncache,
   output logic             l1_shadow_noncache
);
   ssl_pkg::ssl_top_s q;
   ssl_pkg::ssl_top_s d;

   logic [7:0] port;
   logic       aligned;
   logic       is_pri_idx;
   logic       is_pri_data;
   logic       is_smm_idx;
   logic       is_smm_data;
   logic       is_rtc;
   logic       mapped;
   logic [7:0] cfg_idx;
   logic       cfg_acc;
   logic       mem_we;
   logic [7:0] mem_rdata;
   logic [7:0] wd;
   logic       strobe_cpu;
   logic       flush_en;
   logic       force_en;
   logic       entry;
   logic       in_smm;
   logic       kbd_gate;
   logic       gate_d;
   logic       xfer_end;

   // port decode of the apb address
   assign port        = paddr[9:`SSL_PORT_LSB];
   assign aligned     = (paddr[1:0] == 2'h0);
   assign is_pri_idx  = aligned && (port == `SSL_PORT_PRI_IDX);
   assign is_pri_data = aligned && (port == `SSL_PORT_PRI_DATA);
   assign is_smm_idx  = aligned && (port == `SSL_PORT_SMM_IDX); // RULE11
   assign is_smm_data = aligned && (port == `SSL_PORT_SMM_DATA); // RULE11
   assign is_rtc      = aligned && (port == `SSL_PORT_RTC_IDX);
   assign mapped      = is_pri_idx || is_pri_data || is_smm_idx
                        || is_smm_data || is_rtc;
   assign wd          = pwdata[7:0];

   // each window uses its own index and flag into one register space
   assign cfg_idx = is_smm_data ? q.idx_smm : q.idx_pri; // RULE12 RULE13
   assign cfg_acc = is_smm_data ? q.acc_smm : q.acc_pri; // RULE12

   // strobe-type processor bit and the flush and forcing enables it overrides
   assign strobe_cpu = q.cfg94[`SSL_SMM_STROBE_CPU_BIT]; // RULE17
   assign flush_en   = q.cfg94[`SSL_SMM_FLUSH_EN_BIT];
   assign force_en   = q.cfg94[`SSL_SMM_GATE_FORCE_BIT];

   // entry is the falling edge of the static active level
   assign entry    = q.act_n_prev && !mgmt_mode_active_n; // RULE18
   // strobe processors mark mode per bus cycle
   assign in_smm   = strobe_cpu ? !mgmt_mode_addr_strobe_n // RULE19
                                : !mgmt_mode_active_n;
   assign kbd_gate = kbd_addr_bit20_gate || emu_addr_bit20_gate;
   // forcing only for static-level processors
   assign gate_d   = kbd_gate || (force_en && !strobe_cpu // RULE7 RULE10
                                  && !mgmt_mode_active_n);
   assign xfer_end = psel && penable && q.pready;

   // configuration register storage shared by both windows
   ssl_cfg_mem u_mem (
      .pclk    (pclk),
      .presetn (presetn),
      .we      (mem_we),
      .waddr   (cfg_idx),
      .wdata   (wd),
      .raddr   (cfg_idx),
      .rdata   (mem_rdata)
   );

   // next state: apb slave, flush timer, gate and cache controls
   always_comb begin
      d      = q;
      mem_we = 1'b0;
      case (q.st)
         ssl_pkg::SSL_IDLE: begin
            if (psel && !penable) begin
               d.st = ssl_pkg::SSL_BUSY;
            end
         end
         ssl_pkg::SSL_BUSY: begin
            d.st      = ssl_pkg::SSL_DONE;
            d.pready  = 1'b1;
            d.pslverr = !mapped;
            d.prdata  = `SSL_RD_NONE;
            if (!pwrite) begin
               if (is_pri_idx) begin
                  d.prdata = q.idx_pri;
               end else if (is_smm_idx) begin
                  d.prdata = q.idx_smm;
               end else if ((is_pri_data || is_smm_data) && cfg_acc) begin
                  if (cfg_idx == `SSL_CFG_RTC_SHADOW) begin
                     d.prdata = q.rtc_idx; // RULE15
                  end else begin
                     d.prdata = mem_rdata; // RULE13
                  end
               end
            end
         end
         ssl_pkg::SSL_DONE: begin
            d.st      = ssl_pkg::SSL_IDLE;
            d.pready  = 1'b0;
            d.pslverr = 1'b0;
            if (xfer_end && pwrite) begin
               if (is_pri_idx) begin
                  d.idx_pri = wd;
                  d.acc_pri = 1'b1;
               end
               if (is_smm_idx) begin
                  d.idx_smm = wd; // RULE12
                  d.acc_smm = 1'b1; // RULE12
               end
               if (is_rtc) begin
                  d.rtc_idx = wd; // RULE15
               end
               if ((is_pri_data || is_smm_data) && cfg_acc) begin
                  mem_we = 1'b1; // RULE13
                  if (cfg_idx == `SSL_CFG_SHADOW) begin
                     d.cfg18 = wd;
                  end
                  if (cfg_idx == `SSL_CFG_SMM) begin
                     d.cfg94 = wd;
                  end
               end
            end
            // a data access consumes only its own window's flag
            if (xfer_end && is_pri_data) begin
               d.acc_pri = 1'b0;
            end
            if (xfer_end && is_smm_data) begin
               d.acc_smm = 1'b0; // RULE12
            end
         end
         default: begin
            d.st = ssl_pkg::SSL_IDLE;
         end
      endcase

      // flush pulse only on entry; nothing at exit or for the l2
      d.act_n_prev = mgmt_mode_active_n;
      if (q.flush_cnt != 3'h0) begin
         d.flush_cnt = q.flush_cnt - 3'h1; // RULE1
      end else if (entry && flush_en && !strobe_cpu) begin // RULE2 RULE3
         d.flush_cnt = `SSL_FLUSH_CYCLES; // RULE1
      end
      d.flush_n = (d.flush_cnt == 3'h0); // RULE20

      // link codes mark every change of the combined gate
      d.gate     = gate_d;
      d.gate_set = gate_d && !q.gate; // RULE8 RULE9
      d.gate_clr = !gate_d && q.gate; // RULE8 RULE9

      // cacheability controls
      d.l1_smm_nc = q.cfg94[`SSL_SMM_L1_NC_BIT] && in_smm; // RULE4 RULE6
      d.l2_nc     = q.cfg18[`SSL_SHADOW_L2_NC_BIT]; // RULE5 RULE6
      d.l1_sh_nc  = q.cfg18[`SSL_SHADOW_L1_NC_BIT]; // RULE6
   end

   // state register with constant reset values
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q            <= '0;
         q.st         <= ssl_pkg::SSL_IDLE;
         q.idx_pri    <= `SSL_IDX_RESET;
         q.idx_smm    <= `SSL_IDX_RESET;
         q.cfg18      <= `SSL_CFG_RESET;
         q.cfg94      <= `SSL_CFG_RESET;
         q.act_n_prev <= 1'b1;
         q.flush_n    <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // outputs straight from the state register
   assign prdata               = {24'h000000, q.prdata};
   assign pready               = q.pready;
   assign pslverr              = q.pslverr;
   assign cache_flush_n        = q.flush_n;
   assign addr_bit20_gate      = q.gate;
   assign gate_set_link_code   = q.gate_set;
   assign gate_clear_link_code = q.gate_clr;
   assign l1_smm_noncache      = q.l1_smm_nc;
   assign l2_shadow_noncache   = q.l2_nc;
   assign l1_shadow_noncache   = q.l1_sh_nc;

   // checks on the driven outputs and on internal registers
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_flush_len: // RULE1 RULE20
   assert property ($fell(cache_flush_n) |->
                    !cache_flush_n [*4] ##1 cache_flush_n)
      else $error("flush pulse not four cycles");

   a_flush_cause: // RULE1 RULE3
   assert property ($fell(cache_flush_n) |->
                    $past(entry) && $past(flush_en))
      else $error("flush without enabled entry");

   a_flush_strobe: // RULE2
   assert property ($fell(cache_flush_n) |-> !$past(strobe_cpu))
      else $error("flush for strobe processor");

   a_gate_code: // RULE8
   assert property (gate_set_link_code |->
                    addr_bit20_gate && !$past(addr_bit20_gate))
      else $error("set code without gate rise");

   a_clear_code: // RULE8
   assert property (gate_clear_link_code |->
                    !addr_bit20_gate && $past(addr_bit20_gate))
      else $error("clear code without gate fall");

   a_gate_quiet: // RULE9
   assert property ($past(kbd_gate) && kbd_gate |=>
                    !gate_set_link_code && !gate_clear_link_code)
      else $error("code sent with gate already high");

   a_gate_strobe: // RULE10
   assert property (strobe_cpu && !kbd_gate |=> !addr_bit20_gate)
      else $error("gate forced for strobe processor");

   a_force_mode: // RULE7
   assert property (force_en && !strobe_cpu && !mgmt_mode_active_n
                    |=> addr_bit20_gate)
      else $error("gate not forced in mode");

   a_ready_time: // APB slave port answer timing
   assert property (psel && !penable && q.st == ssl_pkg::SSL_IDLE
                    |=> !pready ##1 pready ##1 !pready)
      else $error("apb answer timing wrong");

   a_window_indep: // RULE12
   assert property (xfer_end && pwrite && is_smm_idx |=>
                    $stable(q.acc_pri) && $stable(q.idx_pri))
      else $error("second window disturbed primary");

   a_rtc_shadow: // RULE15
   assert property (xfer_end && pwrite && is_rtc |=>
                    q.rtc_idx == $past(pwdata[7:0]))
      else $error("port 70 write not captured");

   a_l1_mode: // RULE4
   assert property (q.cfg94[`SSL_SMM_L1_NC_BIT] && in_smm
                    ##1 q.cfg94[`SSL_SMM_L1_NC_BIT] |-> l1_smm_noncache)
      else $error("mode space cached in l1");

   c_flush: cover property ($fell(cache_flush_n));
   c_gate_set: cover property (gate_set_link_code && !kbd_gate);
   c_smm_read: cover property (xfer_end && !pwrite && is_smm_data
                               && q.acc_smm);
   c_rtc_write: cover property (xfer_end && pwrite && is_rtc);

endmodule : ssl_support

// ---- src/ssl_regs.svh ----
// ssl_regs.svh: port map, config indices, field positions and counts
`ifndef SSL_REGS_SVH
`define SSL_REGS_SVH

// i/o ports, reached over apb at byte address = port * 4
`define SSL_PORT_LSB           2
`define SSL_PORT_PRI_IDX       8'h22
`define SSL_PORT_PRI_DATA      8'h23
`define SSL_PORT_SMM_IDX       8'h26
`define SSL_PORT_SMM_DATA      8'h27
`define SSL_PORT_RTC_IDX       8'h70

// configuration register indices
`define SSL_CFG_SHADOW         8'h18
`define SSL_CFG_SMM            8'h94
`define SSL_CFG_RTC_SHADOW     8'h96

// field positions
`define SSL_SHADOW_L2_NC_BIT   3
`define SSL_SHADOW_L1_NC_BIT   2
`define SSL_SMM_L1_NC_BIT      3
`define SSL_SMM_GATE_FORCE_BIT 2
`define SSL_SMM_FLUSH_EN_BIT   4
`define SSL_SMM_STROBE_CPU_BIT 5

// reset values and read filler
`define SSL_CFG_RESET          8'h00
`define SSL_IDX_RESET          8'h00
`define SSL_RD_NONE            8'h00

// flush pulse length in clock cycles
`define SSL_FLUSH_CYCLES       3'h4

`endif

// ---- src/ssl_pkg.sv ----
// ssl_pkg: state types of the management-mode support logic
package ssl_pkg;

   typedef enum logic [1:0] {SSL_IDLE, SSL_BUSY, SSL_DONE} ssl_state_e;

   typedef struct packed {
      ssl_state_e st;
      logic       pready;
      logic       pslverr;
      logic [7:0] prdata;
      logic [7:0] idx_pri;
      logic       acc_pri;
      logic [7:0] idx_smm;
      logic       acc_smm;
      logic [7:0] cfg18;
      logic [7:0] cfg94;
      logic [7:0] rtc_idx;
      logic       act_n_prev;
      logic [2:0] flush_cnt;
      logic       flush_n;
      logic       gate;
      logic       gate_set;
      logic       gate_clr;
      logic       l1_smm_nc;
      logic       l2_nc;
      logic       l1_sh_nc;
   } ssl_top_s;

   typedef struct packed {
      logic [255:0][7:0] cells;
      logic [7:0]        rdata;
   } ssl_mem_s;

endpackage : ssl_pkg

// ---- src/ssl_cfg_mem.sv ----
// ssl_cfg_mem: configuration register storage with registered read
`timescale 1ns/1ps
module ssl_cfg_mem (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       we,
   input  wire logic [7:0] waddr,
   input  wire logic [7:0] wdata,
   input  wire logic [7:0] raddr,
   output logic      [7:0] rdata
);
   ssl_pkg::ssl_mem_s q;
   ssl_pkg::ssl_mem_s d;

   // write port and registered read port
   always_comb begin
      d = q;
      if (we) begin
         d.cells[waddr] = wdata;
      end
      d.rdata = q.cells[raddr]; // old data on same-address collision
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign rdata = q.rdata;

endmodule : ssl_cfg_mem

// ---- verification/ssl_cpu_model.sv ----
// ssl_cpu_model: processor and companion-link stand-in for the bench
`timescale 1ns/1ps
module ssl_cpu_model (
   input  wire logic       pclk,
   input  wire logic       in_mode,
   input  wire logic       strobe_cpu,
   input  wire logic       cache_flush_n,
   input  wire logic       gate_set_link_code,
   input  wire logic       gate_clear_link_code,
   output logic            mgmt_mode_active_n,
   output logic            mgmt_mode_addr_strobe_n,
   output logic      [7:0] flush_cnt,
   output logic      [7:0] set_cnt,
   output logic      [7:0] clr_cnt
);
   logic [1:0] ph;

   // idle processor, empty tallies
   initial begin
      ph = 2'h0;
      mgmt_mode_active_n = 1'b1;
      mgmt_mode_addr_strobe_n = 1'b1;
      flush_cnt = 8'h00;
      set_cnt = 8'h00;
      clr_cnt = 8'h00;
   end

   // mode signalling and tally of flush cycles and link codes
   always @(posedge pclk) begin
      ph <= ph + 2'h1;
      // the level pin falls for strobe processors too, so that only the
      // config bit keeps flush and gate forcing away
      mgmt_mode_active_n <= !in_mode;
      mgmt_mode_addr_strobe_n <= !(in_mode && strobe_cpu
                                   && ph == 2'h0);
      flush_cnt <= flush_cnt + {7'h00, !cache_flush_n};
      set_cnt <= set_cnt + {7'h00, gate_set_link_code};
      clr_cnt <= clr_cnt + {7'h00, gate_clear_link_code};
   end
endmodule : ssl_cpu_model

// ---- verification/ssl_support_bench.sv ----
// ssl_support_bench: self-checking bench of the mode support logic
`timescale 1ns/1ps
module ssl_support_bench;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [9:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic        act_n, stb_n, kbd, emu, flush_n, gate, set_c, clr_c;
   logic        l1_smm, l2_sh, l1_sh, in_mode, stb_cpu;
   logic [7:0]  f_cnt, s_cnt, c_cnt, f0, s0, c0, v;
   logic [32:0] notes[$];
   logic [32:0] nt;
   integer      bad_count, n_tests, seed, i;

   ssl_support u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .mgmt_mode_active_n(act_n), .mgmt_mode_addr_strobe_n(stb_n),
      .kbd_addr_bit20_gate(kbd), .emu_addr_bit20_gate(emu),
      .cache_flush_n(flush_n), .addr_bit20_gate(gate),
      .gate_set_link_code(set_c), .gate_clear_link_code(clr_c),
      .l1_smm_noncache(l1_smm), .l2_shadow_noncache(l2_sh),
      .l1_shadow_noncache(l1_sh));

   ssl_cpu_model u_cpu (.pclk(pclk), .in_mode(in_mode),
      .strobe_cpu(stb_cpu), .cache_flush_n(flush_n),
      .gate_set_link_code(set_c), .gate_clear_link_code(clr_c),
      .mgmt_mode_active_n(act_n), .mgmt_mode_addr_strobe_n(stb_n),
      .flush_cnt(f_cnt), .set_cnt(s_cnt), .clr_cnt(c_cnt));

   // 250 mhz clock
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   task automatic cmp_bus(input logic [32:0] e, g);
      n_tests = n_tests + 1;
      if (g !== e) begin
         bad_count = bad_count + 1;
         $display("Error apb expected %h seen %h", e, g);
      end
   endtask : cmp_bus

   task automatic cmp_val(input string nm, input logic [7:0] e, g);
      n_tests = n_tests + 1;
      if (g !== e) begin
         bad_count = bad_count + 1;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp_val

   // one apb transfer; the expected {pslverr, prdata} is queued first
   task automatic apb(input logic w, input logic [7:0] p,
                      input logic [31:0] d, input logic [32:0] e);
      integer n;
      notes.push_back(e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {p, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      while (pready !== 1'b1 && n < 50) begin
         @(negedge pclk);
         n = n + 1;
      end
      cmp_val("pready", 8'h01, {7'h0, pready});
      @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] p, d);
      apb(1'b1, p, {24'h0, d}, 33'h0);
   endtask : wr

   task automatic rd(input logic [7:0] p, input logic [32:0] e);
      apb(1'b0, p, $random(seed), e);
   endtask : rd

   // one stay in management mode, sources given as {strobe cpu, kbd, emu}
   task automatic visit(input logic [7:0] ef, es, input logic eg, el,
                        input logic [2:0] src);
      @(posedge pclk);
      {stb_cpu, kbd, emu} <= src;
      repeat (4) @(posedge pclk);
      f0 = f_cnt;
      s0 = s_cnt;
      c0 = c_cnt;
      in_mode <= 1'b1;
      repeat (12) @(posedge pclk);
      @(negedge pclk);
      cmp_val("flush_entry", ef, f_cnt - f0);
      cmp_val("set_code", es, s_cnt - s0);
      cmp_val("gate", {7'h0, eg}, {7'h0, gate});
      cmp_val("l1_smm", {7'h0, el}, {7'h0, l1_smm});
      @(posedge pclk);
      in_mode <= 1'b0;
      repeat (12) @(posedge pclk);
      @(negedge pclk);
      cmp_val("flush_exit", ef, f_cnt - f0);
      cmp_val("clear_code", es, c_cnt - c0);
      cmp_val("l1_smm_exit", 8'h00, {7'h0, l1_smm});
      @(posedge pclk);
      {stb_cpu, kbd, emu} <= 3'b000;
      repeat (4) @(posedge pclk);
   endtask : visit

   task automatic final_report;
      if (bad_count == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : final_report

   // each completed transfer is matched against the oldest note
   always @(negedge pclk) begin
      if (pready === 1'b1) begin
         nt = (notes.size() > 0) ? notes.pop_front() : 33'h1ffffffff;
         cmp_bus(nt, {pslverr, prdata});
      end
   end

   // hang guard, far beyond the few hundred cycles the run needs
   initial begin
      #80000;
      bad_count = bad_count + 1;
      final_report;
   end

   // main sequence
   initial begin
      seed = 32'h2152;
      bad_count = 0;
      n_tests = 0;
      {presetn, psel, penable, pwrite, kbd, emu, in_mode, stb_cpu} = 8'h00;
      paddr = 10'h000;
      pwdata = 32'h0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      cmp_val("flush_idle", 8'h01, {7'h0, flush_n});
      wr(8'h22, 8'h94);
      wr(8'h23, 8'h1c);
      wr(8'h26, 8'h94);
      rd(8'h27, 33'h1c);
      wr(8'h22, 8'h18);
      wr(8'h26, 8'h94);
      rd(8'h27, 33'h1c);
      wr(8'h23, 8'h08);
      wr(8'h26, 8'h18);
      rd(8'h27, 33'h08);
      rd(8'h27, 33'h00);
      @(negedge pclk);
      cmp_val("l2_shadow", 8'h01, {7'h0, l2_sh});
      cmp_val("l1_shadow", 8'h00, {7'h0, l1_sh});
      visit(8'h04, 8'h01, 1'b1, 1'b1, 3'b000);
      visit(8'h04, 8'h00, 1'b1, 1'b1, 3'b010);
      visit(8'h04, 8'h00, 1'b1, 1'b1, 3'b001);
      wr(8'h26, 8'h94);
      wr(8'h27, 8'h34);
      visit(8'h00, 8'h00, 1'b0, 1'b0, 3'b100);
      for (i = 0; i < 3; i = i + 1) begin
         v = 8'($random(seed));
         wr(8'h70, v);
         wr(8'h26, 8'h96);
         rd(8'h27, {25'h0, v});
      end
      rd(8'h70, 33'h0);
      rd(8'h24, 33'h100000000);
      // mid-run reset clears config, indices and flags
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      cmp_val("l2_reset", 8'h00, {7'h0, l2_sh});
      rd(8'h26, 33'h0);
      wr(8'h26, 8'h94);
      rd(8'h27, 33'h0);
      wr(8'h26, 8'h18);
      wr(8'h27, 8'h04);
      @(posedge pclk);
      @(negedge pclk);
      cmp_val("l1_shadow_set", 8'h01, {7'h0, l1_sh});
      final_report;
   end
endmodule : ssl_support_bench
